// File: design/tcd_defines.vh
`ifndef TCD_DEFINES_VH
`define TCD_DEFINES_VH
// ----------------
// Register byte offsets
// ----------------
`define TCD_A_CODE0  8'h00
`define TCD_A_CODE1  8'h04
`define TCD_A_CODE2  8'h08
`define TCD_A_CTRL   8'h0C
`define TCD_A_CMD    8'h10
`define TCD_A_STAT   8'h14
`define TCD_A_RES0   8'h18
`define TCD_A_RES1   8'h1C
`define TCD_A_RES2   8'h20
`define TCD_A_RES3   8'h24
// ----------------
// Command bit positions
// ----------------
`define TCD_CMD_DEC  0
`define TCD_CMD_ARM  1
`define TCD_CMD_DAC  2
`define TCD_CMD_DDC  3
`define TCD_CMD_STOP 4
// ----------------
// Code format
// ----------------
`define TCD_CODE_LEN 4'hB
`define TCD_VAR_CODE 6'h23
`define TCD_MAX_TIME 6'h1A
// ----------------
// Timing
// ----------------
`define TCD_CLK_HZ      10000000
`define TCD_GUARD_MS    150
`define TCD_PRB_OPEN_MS 120
`define TCD_PRB_SHUT_MS 90
`define TCD_GUARD_CYC    (`TCD_GUARD_MS * (`TCD_CLK_HZ / 1000))
`define TCD_PRB_OPEN_CYC (`TCD_PRB_OPEN_MS * (`TCD_CLK_HZ / 1000))
`define TCD_PRB_SHUT_CYC (`TCD_PRB_SHUT_MS * (`TCD_CLK_HZ / 1000))
// ----------------
// Limits in 10 V units, times in 0.1 s
// ----------------
`define TCD_AC_MAX  10'h1F4
`define TCD_DC_MAX  10'h258
`define TCD_HV_MIN  10'h00A
`define TCD_IR_V0   10'h019
`define TCD_IR_V1   10'h032
`define TCD_IR_V2   10'h064
`define TCD_COL_V   10'h0A0
`define TCD_STEP_V  10'h005
// ----------------
// Factory defaults
// ----------------
`define TCD_DEF_AC_V  10'h0FA
`define TCD_DEF_DC_V  10'h032
`define TCD_DEF_T2S   16'h0014
`define TCD_DEF_T10S  16'h0064
`define TCD_DEF_TRIPL 8'h46
`define TCD_DEF_TRIPH 8'h64
`define TCD_DEF_ARC   4'h5
`define TCD_DEF_NTST  4'h1
`endif

// File: design/tcd_decoder.v
// How it works
// RQ1: Code is eleven characters of 0-9 or A-Z, digit 1 leftmost.
// RQ2: Digit 1 must equal the single maker character.
// RQ3: Digit 2 codes 0-4: skip, AC 50Hz, AC 60Hz, DC, insulation.
// RQ4: Earth bond variant adds 5 and 6 as earth bond 50/60Hz.
// RQ5: Two-channel variant: 0-F with channel 1, G-V without.
// RQ6: Digit 3 column adds base 0, 1.6, 3.2 or 4.8 kV.
// RQ7: Fifth column rejected for HV; earth bond accepts first column only.
// RQ8: Digit 3 row picks one of seven start conditions.
// RQ9: No start with guard open; guard opening aborts a running test.
// RQ10: Guard must be open 150ms then closed 150ms.
// RQ11: Earth bond and powered tests OR probe switch with START.
// RQ12: Then probe open 120ms and closed 90ms before start.
// RQ13: Powered tests add column 0-4 to the loop index.
// RQ14: Target equals base plus digit 4 offset.
// RQ15: Target reached after ramp and held through hold time.
// RQ16: Digit 5 variable code makes target an upper limit.
// RQ17: AC target 0.1-5.00kV, DC target 0.1-6.00kV.
// RQ18: Insulation target only 0.25, 0.5 or 1.0 kV.
// RQ19: Invalid field combinations are rejected.
// RQ20: A 0.00kV target gives no output, a rest step.
// RQ21: Default AC: 2s/10s/2s, 2.5kV, 7/10mA, arc 5, one test.
// RQ22: Default DC: 2s each, 0.5kV, 7/10mA, arc 5, one test.
// RQ23: Digit 4 0-V is offset in 0.05kV steps up to 1.55kV.
// RQ24: Digits 5-7 pick ramp, hold, fall times 0.1-180 s; here digit 0 gives 0 s.
// RQ25: Bad characters or wrong length flagged before field decode.
`default_nettype none
`include "tcd_defines.vh"
module tcd_decoder #(
   parameter [1:0]  VARIANT   = 2'h0,  // 0 basic, 1 two-channel, 2 earth bond, 3 powered
   parameter [7:0]  MAKER_CH  = 8'h4B, // Arbitrary value
   parameter [31:0] GUARD_CYC = `TCD_GUARD_CYC,
   parameter [31:0] POPEN_CYC = `TCD_PRB_OPEN_CYC,
   parameter [31:0] PSHUT_CYC = `TCD_PRB_SHUT_CYC
) (
   input  wire        CORE_CLK,
   input  wire        RESET_N,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   input  wire        GUARD_CLOSED,
   input  wire        START_BTN,
   input  wire        PROBE_SW,
   input  wire        TEST_DONE,
   output reg         TEST_RUN,
   output reg         HV_OUT_EN,
   output reg         START_KEY_EN,
   output reg  [9:0]  TARGET_V,
   output reg  [3:0]  TEST_TYPE,
   output reg         CH1_USE,
   output reg         VAR_LIMIT
);
// ----------------
// State codes
// ----------------
localparam [6:0] S_IDLE  = 7'h01;
localparam [6:0] S_GOPEN = 7'h02;
localparam [6:0] S_GSHUT = 7'h04;
localparam [6:0] S_AOPEN = 7'h08;
localparam [6:0] S_ASHUT = 7'h10;
localparam [6:0] S_KEY   = 7'h20;
localparam [6:0] S_RUN   = 7'h40;
// ----------------
// Character helpers
// ----------------
function [6:0] ch_val;
   input [7:0] c;
   begin
      if (c >= 8'h30 && c <= 8'h39) ch_val = {1'b1, c[5:0] - 6'h30};
      else if (c >= 8'h41 && c <= 8'h5A) ch_val = {1'b1, c[5:0] - 6'h01 + 6'h0A};
      else ch_val = 7'h00;
   end
endfunction
function [15:0] t_tab;
   input [5:0] v;
   begin
      case (v)
         6'h0A:   t_tab = 16'h000A;
         6'h0B:   t_tab = 16'h000F;
         6'h0C:   t_tab = 16'h0014;
         6'h0D:   t_tab = 16'h001E;
         6'h0E:   t_tab = 16'h0028;
         6'h0F:   t_tab = 16'h0032;
         6'h10:   t_tab = 16'h004B;
         6'h11:   t_tab = 16'h0064;
         6'h12:   t_tab = 16'h0096;
         6'h13:   t_tab = 16'h00C8;
         6'h14:   t_tab = 16'h012C;
         6'h15:   t_tab = 16'h01C2;
         6'h16:   t_tab = 16'h0258;
         6'h17:   t_tab = 16'h0384;
         6'h18:   t_tab = 16'h04B0;
         6'h19:   t_tab = 16'h05DC;
         6'h1A:   t_tab = 16'h0708;
         default: t_tab = {10'h000, v};
      endcase
   end
endfunction
// ----------------
// Registers
// ----------------
reg  [31:0] code0_ff, code1_ff, code2_ff;
reg  [1:0]  vsel_ff;
reg  [3:0]  len_ff;
reg         valid_ff, err_ff, abort_ff, first_ff;
reg  [2:0]  cond_ff;
reg  [2:0]  loop_ff;
reg  [15:0] ramp_ff, hold_ff, fall_ff;
reg  [7:0]  tripl_ff, triph_ff;
reg  [3:0]  arc_ff, ntst_ff;
reg  [6:0]  st_ff;
reg  [31:0] cnt_ff;
reg         btn_ff;
// ----------------
// Field decode
// ----------------
wire [87:0] str = {code2_ff[23:0], code1_ff, code0_ff};
reg  [10:0] okc;
reg  [5:0]  dv [0:10];
reg  [6:0]  chv;
integer     i;
always @* begin
   chv = 7'h00;
   for (i = 0; i < 11; i = i + 1) begin
      chv    = ch_val(str[8*i +: 8]);
      okc[i] = chv[6];
      dv[i]  = chv[5:0];
   end
end
wire        fmt_ok = (&okc) && (len_ff == `TCD_CODE_LEN); // see RQ1 see RQ25
wire        mk_ok  = (str[7:0] == MAKER_CH);               // see RQ2
wire [5:0]  d2 = dv[1];
wire [5:0]  d3 = dv[2];
wire [5:0]  d4 = dv[3];
wire [2:0]  col = (d3 >= 6'h23) ? 3'h5 : (d3 >= 6'h1C) ? 3'h4 :
                  (d3 >= 6'h15) ? 3'h3 : (d3 >= 6'h0E) ? 3'h2 :
                  (d3 >= 6'h07) ? 3'h1 : 3'h0;
wire [5:0]  row6 = d3 - {col, 3'h0} + {3'h0, col};          // see RQ8
reg  [3:0]  typ;
reg         ch1, t_ok;
always @* begin
   typ  = d2[3:0];
   ch1  = 1'b1;                                            // see RQ5
   t_ok = 1'b0;
   case (vsel_ff)
      2'h1: begin
         ch1  = (d2 < 6'h10);                              // see RQ5
         typ  = d2[3:0];
         t_ok = (d2 < 6'h20) && (d2[3:0] <= 4'h4);
      end
      2'h2: t_ok = (d2 <= 6'h06);                          // see RQ4
      2'h3: begin
         if (d2 >= 6'h11 && d2 <= 6'h18) begin
            typ = d2[3:0] - 4'h0;
         end
         t_ok = (d2 <= 6'h08) || (d2 >= 6'h11 && d2 <= 6'h14) ||
                (d2 == 6'h17) || (d2 == 6'h18);
      end
      default: t_ok = (d2 <= 6'h04);                       // see RQ3
   endcase
end
wire        is_hv  = (typ >= 4'h1) && (typ <= 4'h4);
wire        is_eb  = (typ == 4'h5) || (typ == 4'h6);
wire        is_pw  = (typ == 4'h7) || (typ == 4'h8);
wire [9:0]  base   = is_hv ? (`TCD_COL_V * {7'h00, col}) : 10'h000; // see RQ6 see RQ13
wire [9:0]  offs   = `TCD_STEP_V * {4'h0, d4};                      // see RQ23
wire [9:0]  tgt    = base + offs;                                   // see RQ14
wire        v_ok   = (tgt == 10'h000) ||                            // see RQ20
   ((typ == 4'h1 || typ == 4'h2) && tgt >= `TCD_HV_MIN && tgt <= `TCD_AC_MAX) ||
   ((typ == 4'h3) && tgt >= `TCD_HV_MIN && tgt <= `TCD_DC_MAX);     // see RQ17
wire        ir_ok  = (tgt == `TCD_IR_V0) || (tgt == `TCD_IR_V1) ||
                     (tgt == `TCD_IR_V2);                           // see RQ18
wire        c_ok   = is_hv ? (col <= 3'h3 && d4 <= 6'h1F) :         // see RQ7
                     is_eb ? (col == 3'h0) :
                     is_pw ? (col <= 3'h4) : (col <= 3'h4);
wire        lv_ok  = !is_hv || ((typ == 4'h4) ? ir_ok : v_ok);
wire        tm_ok  = (dv[4] <= `TCD_MAX_TIME || dv[4] == `TCD_VAR_CODE) &&
                     dv[5] <= `TCD_MAX_TIME && dv[6] <= `TCD_MAX_TIME; // see RQ24
wire        all_ok = fmt_ok && mk_ok && t_ok && c_ok && lv_ok && tm_ok; // see RQ19
// ----------------
// APB slave
// ----------------
wire        acc  = PSEL && PENABLE && !PREADY;
wire        wr   = PSEL && PENABLE && PREADY && PWRITE; // Lands with the PREADY edge
wire        cmdw = wr && (PADDR == `TCD_A_CMD);
wire        dec  = cmdw && PWDATA[`TCD_CMD_DEC];
wire        arm  = cmdw && PWDATA[`TCD_CMD_ARM] && valid_ff && !dec;
wire        d_ac = cmdw && PWDATA[`TCD_CMD_DAC];
wire        d_dc = cmdw && PWDATA[`TCD_CMD_DDC] && !d_ac;
wire        stop = cmdw && PWDATA[`TCD_CMD_STOP];
wire [31:0] stat = {25'h0, first_ff, START_KEY_EN, abort_ff, TEST_RUN,
                    !st_ff[0], err_ff, valid_ff};
reg  [31:0] nxt_rd;
reg         nxt_bad;
always @* begin
   nxt_bad = 1'b0;
   case (PADDR)
      `TCD_A_CODE0: nxt_rd = code0_ff;
      `TCD_A_CODE1: nxt_rd = code1_ff;
      `TCD_A_CODE2: nxt_rd = {8'h00, code2_ff[23:0]};
      `TCD_A_CTRL:  nxt_rd = {20'h0, len_ff, 6'h00, vsel_ff};
      `TCD_A_CMD:   nxt_rd = 32'h0;
      `TCD_A_STAT:  nxt_rd = stat;
      `TCD_A_RES0:  nxt_rd = {10'h0, loop_ff, cond_ff, VAR_LIMIT, CH1_USE,
                              TEST_TYPE, TARGET_V};
      `TCD_A_RES1:  nxt_rd = {hold_ff, ramp_ff};
      `TCD_A_RES2:  nxt_rd = {16'h0, fall_ff};
      `TCD_A_RES3:  nxt_rd = {8'h00, ntst_ff, arc_ff, triph_ff, tripl_ff};
      default: begin
         nxt_rd  = 32'h0;
         nxt_bad = 1'b1;
      end
   endcase
end
always @(posedge CORE_CLK or negedge RESET_N) begin
   if (!RESET_N) begin
      PREADY   <= 1'b0;
      PSLVERR  <= 1'b0;
      PRDATA   <= 32'h0;
      code0_ff <= 32'h0;
      code1_ff <= 32'h0;
      code2_ff <= 32'h0;
      vsel_ff  <= 2'h0;
      len_ff   <= 4'h0;
   end else begin
      PREADY  <= acc;
      PSLVERR <= acc && nxt_bad;
      PRDATA  <= (acc && !PWRITE) ? nxt_rd : 32'h0;
      if (wr && PADDR == `TCD_A_CODE0) code0_ff <= PWDATA;
      if (wr && PADDR == `TCD_A_CODE1) code1_ff <= PWDATA;
      if (wr && PADDR == `TCD_A_CODE2) code2_ff <= {8'h00, PWDATA[23:0]};
      if (wr && PADDR == `TCD_A_CTRL) begin
         vsel_ff <= PWDATA[1:0] | VARIANT;
         len_ff  <= PWDATA[11:8];
      end
   end
end
// ----------------
// Decoded result latch
// ----------------
always @(posedge CORE_CLK or negedge RESET_N) begin
   if (!RESET_N) begin
      valid_ff  <= 1'b0;
      err_ff    <= 1'b0;
      TARGET_V  <= 10'h000;
      TEST_TYPE <= 4'h0;
      CH1_USE   <= 1'b1;
      VAR_LIMIT <= 1'b0;
      cond_ff   <= 3'h6;
      loop_ff   <= 3'h0;
      ramp_ff   <= 16'h0;
      hold_ff   <= 16'h0;
      fall_ff   <= 16'h0;
      tripl_ff  <= 8'h00;
      triph_ff  <= 8'h00;
      arc_ff    <= 4'h0;
      ntst_ff   <= 4'h0;
   end else if (dec) begin
      valid_ff <= all_ok;
      err_ff   <= !all_ok;                                // see RQ19
      if (all_ok) begin
         TARGET_V  <= is_hv ? tgt : 10'h000;
         TEST_TYPE <= typ;
         CH1_USE   <= ch1;
         VAR_LIMIT <= (dv[4] == `TCD_VAR_CODE);          // see RQ16
         cond_ff   <= row6[2:0];
         loop_ff   <= is_pw ? col : 3'h0;                // see RQ13
         ramp_ff   <= t_tab(dv[4]);                      // see RQ15
         hold_ff   <= t_tab(dv[5]);
         fall_ff   <= t_tab(dv[6]);
      end
   end else if ((d_ac || d_dc) && st_ff[0]) begin
      valid_ff  <= 1'b1;                                 // see RQ21 see RQ22
      err_ff    <= 1'b0;
      TARGET_V  <= d_ac ? `TCD_DEF_AC_V : `TCD_DEF_DC_V;
      TEST_TYPE <= d_ac ? 4'h1 : 4'h3;
      CH1_USE   <= 1'b1;
      VAR_LIMIT <= 1'b0;
      cond_ff   <= 3'h0;
      loop_ff   <= 3'h0;
      ramp_ff   <= `TCD_DEF_T2S;
      hold_ff   <= d_ac ? `TCD_DEF_T10S : `TCD_DEF_T2S;
      fall_ff   <= `TCD_DEF_T2S;
      tripl_ff  <= `TCD_DEF_TRIPL;
      triph_ff  <= `TCD_DEF_TRIPH;
      arc_ff    <= `TCD_DEF_ARC;
      ntst_ff   <= `TCD_DEF_NTST;
   end
end
// ----------------
// Start sequencer
// ----------------
wire        ebpw   = (TEST_TYPE >= 4'h5) && (TEST_TYPE <= 4'h8);
wire        act    = ebpw ? (START_BTN || PROBE_SW) : START_BTN; // see RQ11
wire        skipa  = cond_ff[0] && first_ff && (cond_ff != 3'h6);
wire        need_g = (cond_ff <= 3'h3) && !skipa;
wire        need_k = (cond_ff <= 3'h1 || cond_ff == 3'h4 || cond_ff == 3'h5) && !skipa;
wire [6:0]  after_g = !need_k ? S_RUN : (ebpw ? S_AOPEN : S_KEY);
reg  [6:0]  nxt_st;
reg  [31:0] nxt_cnt;
always @* begin
   nxt_st  = st_ff;
   nxt_cnt = cnt_ff + 32'h1;
   case (st_ff)
      S_IDLE: begin
         nxt_cnt = 32'h0;
         if (arm) nxt_st = need_g ? S_GOPEN : after_g;
      end
      S_GOPEN: begin
         if (GUARD_CLOSED) begin
            nxt_cnt = 32'h0;
         end else if (cnt_ff + 32'h1 >= GUARD_CYC) begin // see RQ10
            nxt_st  = S_GSHUT;
            nxt_cnt = 32'h0;
         end
      end
      S_GSHUT: begin
         if (!GUARD_CLOSED) begin
            nxt_st  = S_GOPEN;
            nxt_cnt = 32'h0;
         end else if (cnt_ff + 32'h1 >= GUARD_CYC) begin // see RQ10
            nxt_st  = after_g;
            nxt_cnt = 32'h0;
         end
      end
      S_AOPEN: begin
         if (act) begin
            nxt_cnt = 32'h0;
         end else if (cnt_ff + 32'h1 >= POPEN_CYC) begin // see RQ12
            nxt_st  = S_ASHUT;
            nxt_cnt = 32'h0;
         end
      end
      S_ASHUT: begin
         if (!act) begin
            nxt_st  = S_AOPEN;
            nxt_cnt = 32'h0;
         end else if (cnt_ff + 32'h1 >= PSHUT_CYC) begin // see RQ12
            nxt_st  = S_RUN;
            nxt_cnt = 32'h0;
         end
      end
      S_KEY: begin
         nxt_cnt = 32'h0;
         if (START_BTN && !btn_ff) nxt_st = S_RUN;
      end
      S_RUN: begin
         nxt_cnt = 32'h0;
         if (TEST_RUN && (!GUARD_CLOSED || TEST_DONE)) nxt_st = S_IDLE; // see RQ9
      end
      default: nxt_st = S_IDLE;
   endcase
   if (stop || dec) begin
      nxt_st = S_IDLE;
   end
end
wire        go  = (st_ff == S_RUN) && !TEST_RUN && GUARD_CLOSED; // see RQ9
wire        end_run = TEST_RUN && (!GUARD_CLOSED || TEST_DONE || stop || dec);
always @(posedge CORE_CLK or negedge RESET_N) begin
   if (!RESET_N) begin
      st_ff        <= S_IDLE;
      cnt_ff       <= 32'h0;
      btn_ff       <= 1'b0;
      TEST_RUN     <= 1'b0;
      HV_OUT_EN    <= 1'b0;
      START_KEY_EN <= 1'b0;
      abort_ff     <= 1'b0;
      first_ff     <= 1'b0;
   end else begin
      st_ff        <= nxt_st;
      cnt_ff       <= nxt_cnt;
      btn_ff       <= START_BTN;
      START_KEY_EN <= (nxt_st == S_KEY);
      if (end_run) begin
         TEST_RUN  <= 1'b0;
         HV_OUT_EN <= 1'b0;
      end else if (go && !stop && !dec) begin
         TEST_RUN  <= 1'b1;
         HV_OUT_EN <= (TARGET_V != 10'h000) && (TEST_TYPE <= 4'h4); // see RQ20
      end
      if (TEST_RUN && !GUARD_CLOSED) abort_ff <= 1'b1;             // see RQ9
      else if (arm || dec) abort_ff <= 1'b0;
      if (TEST_RUN && TEST_DONE && GUARD_CLOSED) first_ff <= 1'b1; // see RQ8
      else if (dec || d_ac || d_dc) first_ff <= 1'b0;
   end
end
endmodule // tcd_decoder
`default_nettype wire

// File: testbench/tcd_chk.sv
`default_nettype none
module tcd_chk (
   input wire logic       CORE_CLK,
   input wire logic       RESET_N,
   input wire logic       PSEL,
   input wire logic       PENABLE,
   input wire logic       PREADY,
   input wire logic       PSLVERR,
   input wire logic       GUARD_CLOSED,
   input wire logic       TEST_DONE,
   input wire logic       TEST_RUN,
   input wire logic       HV_OUT_EN,
   input wire logic [9:0] TARGET_V,
   input wire logic [3:0] TEST_TYPE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);

   property p_rdy_one;
      PSEL && PENABLE && !PREADY |=> PREADY;
   endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("ready late");
   property p_rdy_pulse;
      PREADY |=> !PREADY;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
   property p_err_rdy;
      PSLVERR |-> PREADY && PSEL && PENABLE;
   endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
   property p_start_guard;
      $rose(TEST_RUN) |-> $past(GUARD_CLOSED);
   endproperty
   a_start_guard: assert property (p_start_guard) else $error("start with guard open");
   property p_abort;
      TEST_RUN && !GUARD_CLOSED |=> !TEST_RUN;
   endproperty
   a_abort: assert property (p_abort) else $error("no abort on guard open");
   property p_done;
      TEST_RUN && TEST_DONE |=> !TEST_RUN;
   endproperty
   a_done: assert property (p_done) else $error("run after done");
   property p_rest;
      HV_OUT_EN |-> TEST_RUN && TARGET_V != 10'h000;
   endproperty
   a_rest: assert property (p_rest) else $error("output on rest step");
   property p_ac_rng;
      TEST_RUN && (TEST_TYPE == 4'h1 || TEST_TYPE == 4'h2) |-> TARGET_V <= 10'h1F4;
   endproperty
   a_ac_rng: assert property (p_ac_rng) else $error("ac target high");
   property p_dc_rng;
      TEST_RUN && TEST_TYPE == 4'h3 |-> TARGET_V <= 10'h258;
   endproperty
   a_dc_rng: assert property (p_dc_rng) else $error("dc target high");
   property p_ir_set;
      TEST_RUN && TEST_TYPE == 4'h4 |-> TARGET_V inside {10'h019, 10'h032, 10'h064};
   endproperty
   a_ir_set: assert property (p_ir_set) else $error("ir target bad");
   property p_hold;
      TEST_RUN ##1 TEST_RUN |-> $stable(TARGET_V);
   endproperty
   a_hold: assert property (p_hold) else $error("target moved in run");

   c_run: cover property ($rose(TEST_RUN));
   c_err: cover property (PSLVERR);
   c_abort: cover property (TEST_RUN && !GUARD_CLOSED);
endmodule // tcd_chk

bind tcd_decoder tcd_chk u_chk (.*);
`default_nettype wire

// File: testbench/tcd_sw_model.sv
`default_nettype none
module tcd_sw_model (
   input  wire logic clk,
   output var logic  guard_closed,
   output var logic  start_btn,
   output var logic  probe_sw,
   output var logic  test_done
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      guard_closed = 1'b1;
      start_btn    = 1'b0;
      probe_sw     = 1'b0;
      test_done    = 1'b0;
   end
   task automatic set_guard(input logic v);
      guard_closed <= v;
   endtask
   task automatic guard_seq(input int t_open, input int t_shut);
      guard_closed <= 1'b0;
      repeat (t_open) @(posedge clk);
      guard_closed <= 1'b1;
      repeat (t_shut) @(posedge clk);
   endtask
   task automatic probe_seq(input int t_open, input int t_shut);
      probe_sw <= 1'b0;
      repeat (t_open) @(posedge clk);
      probe_sw <= 1'b1;
      repeat (t_shut) @(posedge clk);
   endtask
   task automatic press();
      start_btn <= 1'b1;
      repeat (2) @(posedge clk);
      start_btn <= 1'b0;
   endtask
   task automatic done_pulse();
      test_done <= 1'b1;
      @(posedge clk);
      test_done <= 1'b0;
   endtask
endmodule // tcd_sw_model
`default_nettype wire

// File: testbench/tb.sv
`default_nettype none
`include "tcd_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] MK = 8'h4D; // Arbitrary maker character
   localparam int GC = 20;
   localparam int PO = 16;
   localparam int PS = 12;
   logic        core_clk = 1'b0;
   logic        reset_n, psel, penable, pwrite, pslverr, pready, perr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q, stat, res0;
   logic        guard_closed, start_btn, probe_sw, test_done;
   logic        test_run, hv_out_en, start_key_en, ch1_use, var_limit;
   logic [9:0]  target_v;
   logic [3:0]  test_type;
   logic [31:0] rng = 32'd52270;
   int          fail_count = 0;
   int          num_checks = 0;

   always #50 core_clk = ~core_clk;

   tcd_decoder #(.MAKER_CH(MK), .GUARD_CYC(GC), .POPEN_CYC(PO), .PSHUT_CYC(PS)) u_tcd_decoder (
      .CORE_CLK(core_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .GUARD_CLOSED(guard_closed), .START_BTN(start_btn),
      .PROBE_SW(probe_sw), .TEST_DONE(test_done), .TEST_RUN(test_run),
      .HV_OUT_EN(hv_out_en), .START_KEY_EN(start_key_en), .TARGET_V(target_v),
      .TEST_TYPE(test_type), .CH1_USE(ch1_use), .VAR_LIMIT(var_limit));
   tcd_sw_model u_tcd_sw_model (.clk(core_clk), .guard_closed(guard_closed),
      .start_btn(start_btn), .probe_sw(probe_sw), .test_done(test_done));

   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function automatic logic [7:0] ch(int v);
      return (v < 10) ? 8'(8'h30 + v) : 8'(8'h37 + v);
   endfunction
   function automatic int cv(logic [7:0] c);
      return (c < 8'h3A) ? int'(c) - 48 : int'(c) - 55;
   endfunction
   // ----------------
   // Expected decode of one code
   // ----------------
   function automatic bit exp_ok(logic [87:0] c, logic [1:0] vr, output int t, ty,
                                 output bit c1);
      int d3, d4;
      logic [7:0] k;
      ty = cv(c[79:72]);
      d3 = cv(c[71:64]);
      d4 = cv(c[63:56]);
      c1 = 1'b1;
      t = (d3 / 7) * 160 + d4 * 5;
      for (int i = 0; i < 11; i++) begin
         k = c[8*i +: 8];
         if (!((k >= 8'h30 && k <= 8'h39) || (k >= 8'h41 && k <= 8'h5A))) return 0;
      end
      if (c[87:80] !== MK) return 0;
      if (vr == 2'h1 && ty >= 16 && ty <= 20) begin
         ty -= 16;
         c1 = 1'b0;
      end
      if (vr == 2'h2 && (ty == 5 || ty == 6)) return d3 < 7;
      if (ty < 1 || ty > 4 || d3 > 27 || d4 > 31) return 0;
      if (ty == 4) return t == 25 || t == 50 || t == 100;
      return t == 0 || (t >= 10 && t <= (ty == 3 ? 600 : 500));
   endfunction
   // ----------------
   // Bus, compare and closing tasks
   // ----------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(string n, logic e, logic g);
      chk_word(n, {31'h0, e}, {31'h0, g});
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      perr = pslverr;
      chk_bit("pready", 1'b1, pready);
      if (n >= 20) end_of_test();
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic expect_sig(int n, logic want, logic key);
      logic seen;
      seen = 1'b0;
      repeat (n) if (!seen) begin
         @(posedge core_clk);
         seen = ((key ? start_key_en : test_run) === 1'b1);
      end
      chk_bit(key ? "start_key_en" : "test_run", want, seen);
      if (want && !seen) end_of_test();
   endtask
   task automatic dec(logic [87:0] c, logic [1:0] vr, logic [3:0] ln);
      logic [31:0] w [3];
      w = '{default: 32'h0};
      for (int i = 0; i < 11; i++) w[i/4][8*(i%4) +: 8] = c[8*(10-i) +: 8];
      apb(1'b1, `TCD_A_CODE0, w[0]);
      apb(1'b1, `TCD_A_CODE1, w[1]);
      apb(1'b1, `TCD_A_CODE2, w[2]);
      apb(1'b1, `TCD_A_CTRL, {20'h0, ln, 6'h0, vr});
      apb(1'b1, `TCD_A_CMD, 32'h1);
      apb(1'b0, `TCD_A_STAT, 32'h0);
      stat = q;
      apb(1'b0, `TCD_A_RES0, 32'h0);
      res0 = q;
   endtask
   task automatic check_code(logic [87:0] c, logic [1:0] vr);
      int t, ty;
      bit c1, ok;
      dec(c, vr, `TCD_CODE_LEN);
      ok = exp_ok(c, vr, t, ty, c1);
      chk_bit("valid", ok, stat[0]);
      if (ok) begin
         chk_word("type", 32'(ty), {28'h0, res0[13:10]});
         chk_bit("ch1", c1, res0[14]);
         chk_bit("var_limit", c[55:48] == 8'h5A, res0[15]);
         if (ty >= 1 && ty <= 4) chk_word("target", 32'(t), {22'h0, res0[9:0]});
      end
   endtask
   task automatic arm_run(logic [87:0] c, logic [1:0] vr);
      dec(c, vr, `TCD_CODE_LEN);
      apb(1'b1, `TCD_A_CMD, 32'h2);
   endtask
   // ----------------
   // Main sequence
   // ----------------
   initial begin
      logic [87:0] cc [10];
      logic [1:0]  cvr [10];
      {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      chk_bit("run_rst", 1'b0, test_run);
      chk_bit("ch1_rst", 1'b1, ch1_use);
      apb(1'b0, 8'h28, 32'h0);
      chk_bit("slverr", 1'b1, perr);
      chk_word("rd_unmapped", 32'h0, q);
      apb(1'b1, `TCD_A_CMD, 32'h4);
      apb(1'b0, `TCD_A_RES0, 32'h0);
      chk_word("def_ac_v", 32'h0FA, {22'h0, q[9:0]});
      apb(1'b0, `TCD_A_RES1, 32'h0);
      chk_word("def_ac_t", 32'h00640014, q);
      apb(1'b0, `TCD_A_RES3, 32'h0);
      chk_word("def_trip", 32'h00156446, q);
      apb(1'b1, `TCD_A_CMD, 32'h8);
      apb(1'b0, `TCD_A_RES0, 32'h0);
      chk_word("def_dc_v", 32'h032, {22'h0, q[9:0]});
      apb(1'b0, `TCD_A_RES1, 32'h0);
      chk_word("def_dc_t", 32'h00140014, q);
      cc = '{{8'h51, "1000000000"}, {MK, "10A000000a"}, {MK, "1S00000000"},
             {MK, "5600000000"}, {MK, "5600000000"}, {MK, "5700000000"},
             {MK, "4050000000"}, {MK, "1LU0000000"}, {MK, "3LK0000000"},
             {MK, "H6AZ000000"}};
      cvr = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h1};
      for (int i = 0; i < 10; i++) check_code(cc[i], cvr[i]);
      repeat (40) check_code({MK, ch(1 + rnd() % 4), ch(rnd() % 35), ch(rnd() % 36),
                              "0000000"}, 2'h0);
      dec({MK, "16A0000000"}, 2'h0, 4'hA);
      chk_bit("valid_len", 1'b0, stat[0]);
      for (int i = 0; i < 2; i++) begin
         arm_run({MK, "16", i == 0 ? "A" : "0", "0000000"}, 2'h0);
         expect_sig(10, 1'b1, 1'b0);
         @(posedge core_clk);
         chk_bit("hv_out_en", i == 0, hv_out_en);
         u_tcd_sw_model.done_pulse();
         @(posedge core_clk);
         chk_bit("run_after_done", 1'b0, test_run);
      end
      u_tcd_sw_model.set_guard(1'b0);
      arm_run({MK, "1660000000"}, 2'h0);
      expect_sig(20, 1'b0, 1'b0);
      apb(1'b1, `TCD_A_CMD, 32'h10);
      u_tcd_sw_model.set_guard(1'b1);
      arm_run({MK, "32A0000000"}, 2'h0);
      u_tcd_sw_model.guard_seq(GC - 2, 40);
      chk_bit("short_open", 1'b0, test_run);
      u_tcd_sw_model.guard_seq(GC, GC - 3);
      chk_bit("early_run", 1'b0, test_run);
      expect_sig(8, 1'b1, 1'b0);
      u_tcd_sw_model.set_guard(1'b0);
      repeat (2) @(posedge core_clk);
      chk_bit("abort", 1'b0, test_run);
      u_tcd_sw_model.set_guard(1'b1);
      apb(1'b0, `TCD_A_STAT, 32'h0);
      chk_bit("aborted", 1'b1, q[4]);
      arm_run({MK, "14A0000000"}, 2'h0);
      expect_sig(8, 1'b1, 1'b1);
      u_tcd_sw_model.press();
      expect_sig(8, 1'b1, 1'b0);
      u_tcd_sw_model.done_pulse();
      arm_run({MK, "54A0000000"}, 2'h2);
      u_tcd_sw_model.probe_seq(PO, PS - 3);
      chk_bit("probe_early", 1'b0, test_run);
      expect_sig(8, 1'b1, 1'b0);
      u_tcd_sw_model.done_pulse();
      end_of_test();
   end
endmodule // tb
`default_nettype wire
